// file: ofs_div_chan.sv
// Edge-counting divider for one output clock channel
`timescale 1ns/100ps
module ofs_div_chan (
   input  wire logic              i_clk,
   input  wire logic              i_srst,
   input  wire ofs_pkg::ofs_sel_t i_sel,
   input  wire logic              i_rise,
   input  wire logic              i_level,
   output logic                   o_clk
);
   import ofs_pkg::*;

   logic [6:0] cnt;
   ofs_sel_t   sel_q;

   // Wrap and duty decode; odd ratios stay high one edge longer
   wire        changed = (i_sel != sel_q);
   wire        wrap    = (cnt == (i_sel.div - 7'h01));
   wire [6:0]  hi_len  = i_sel.div - (i_sel.div >> 1);
   wire        off     = (i_sel.src == SRC_OFF);
   wire        next_clk = off ? 1'b0 : ((i_sel.div == 7'h01) ? i_level : (cnt < hi_len));

   // Restart phase whenever the selection changes
   always_ff @(posedge i_clk) begin
      if (i_srst || changed) begin
         cnt   <= 7'h00;
         o_clk <= 1'b0;
         sel_q <= i_srst ? '0 : i_sel;
      end else begin
         if (i_rise) begin
            cnt <= wrap ? 7'h00 : cnt + 7'h01;
         end
         o_clk <= next_clk;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   a_off_held_low: assert property (i_sel.src == SRC_OFF |=> !o_clk)
      else $error("disabled channel not low");
   a_count_in_range: assert property (sel_q.div > 7'h01 && !changed |-> cnt < sel_q.div)
      else $error("divider count out of range");
   a_pass_level: assert property (
      i_sel.div == 7'h01 && i_sel.src != SRC_OFF && $stable(i_sel) |=> o_clk == $past(i_level))
      else $error("undivided source not passed");

endmodule : ofs_div_chan

// file: ofs_pkg.sv
// Package of constants and types for the output clock frequency selector
package ofs_pkg;

   // Register byte addresses
   localparam logic [7:0] OFS_ADDR_ALT   = 8'h4f;
   localparam logic [7:0] OFS_ADDR_SEL12 = 8'h60;
   localparam logic [7:0] OFS_ADDR_SEL34 = 8'h61;

   // Values after reset
   localparam logic [7:0] OFS_RST_ALT   = 8'h00;
   localparam logic [7:0] OFS_RST_SEL12 = 8'h85;
   localparam logic [7:0] OFS_RST_SEL34 = 8'h86;

   // Writable bits of the alternate-decode register, bit 7 reads zero
   localparam logic [7:0] OFS_ALT_MASK = 8'h7f;

   // Field positions
   localparam int unsigned OFS_OUT1_LSB     = 0;
   localparam int unsigned OFS_OUT2_LSB     = 4;
   localparam int unsigned OFS_OUT4_LSB     = 4;
   localparam int unsigned OFS_ALT_BIT_OUT1 = 0;
   localparam int unsigned OFS_ALT_BIT_OUT2 = 1;
   localparam int unsigned OFS_ALT_BIT_OUT4 = 3;

   // Channel numbers of the three driven pins
   localparam logic [1:0] OFS_CH_A = 2'h0;
   localparam logic [1:0] OFS_CH_B = 2'h1;
   localparam logic [1:0] OFS_CH_D = 2'h2;
   localparam int unsigned OFS_NUM_CH  = 3;
   localparam int unsigned OFS_NUM_SRC = 9;

   // Divider ratio; a ratio of one passes the source level through
   typedef logic [6:0] ofs_div_t;

   // Clock source choice; code minus one is the bit of ofs_src_in_t
   typedef enum logic [3:0] {
      SRC_OFF      = 4'h0,
      SRC_2K       = 4'h1,
      SRC_8K       = 4'h2,
      SRC_SYN_A    = 4'h3,
      SRC_SYN_B    = 4'h4,
      SRC_MAIN     = 4'h5,
      SRC_MAIN2    = 4'h6,
      SRC_AUX      = 4'h7,
      SRC_REF_AUX  = 4'h8,
      SRC_REF_MAIN = 4'h9
   } ofs_src_t;

   typedef struct packed {
      ofs_src_t src;
      ofs_div_t div;
   } ofs_sel_t;

   // Source clocks, last field in bit 0
   typedef struct packed {
      logic ref_main;
      logic ref_aux;
      logic aux_analog_pll;
      logic main_analog_pll_second;
      logic main_analog_pll;
      logic synth_rate_b;
      logic synth_rate_a;
      logic fs_8k;
      logic fs_2k;
   } ofs_src_in_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ofs_reg_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } ofs_reg_rsp_t;

endpackage : ofs_pkg

// file: ofs_tb_top.sv
// Self-checking testbench for the output clock frequency selector
`timescale 1ns/100ps
module ofs_tb_top;
   import ofs_pkg::*;

   // Source half periods in cycles, in ofs_src_in_t bit order
   localparam int HP[9] = '{7, 8, 9, 10, 4, 6, 5, 11, 12};
   localparam int MD[6] = '{48, 16, 12, 8, 6, 4};
   localparam int XD[4] = '{48, 16, 8, 4};

   logic         i_clk;
   logic         i_srst;
   ofs_reg_req_t i_reg;
   ofs_src_in_t  i_src;
   ofs_reg_rsp_t o_reg;
   logic [2:0]   o_ck;
   int           fails;
   int           n_checks;
   int           cyc;

   ofs_top ofs_top_inst (.i_clk(i_clk), .i_srst(i_srst), .i_reg(i_reg), .i_src(i_src), .o_reg(o_reg),
      .o_clock_out_a(o_ck[0]), .o_clock_out_b(o_ck[1]), .o_clock_out_d(o_ck[2]));

   // Clock
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   // Free-running source clocks and run limit
   always @(posedge i_clk) begin
      #1;
      cyc = cyc + 1;
      for (int i = 0; i < 9; i++) begin
         i_src[i] = ((cyc / HP[i]) % 2) == 1;
      end
      if (cyc > 60000) begin
         fails = fails + 1;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : cmp_byte

   task automatic cmp_per(input int exp, input int got);
      n_checks++;
      if (got != exp) begin
         fails++;
         $display("Error at %0t: period expected %h got %h", $time, exp, got);
      end
   endtask : cmp_per

   // Register cycles, one idle cycle after each
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      i_reg = '{1'b1, 1'b0, a, d};
      @(posedge i_clk) #1;
      i_reg = '0;
      @(posedge i_clk) #1;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      i_reg = '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_clk) #1;
      i_reg = '0;
      cmp_byte(8'h01, {7'h00, o_reg.valid});
      cmp_byte(exp, o_reg.data);
      @(posedge i_clk) #1;
      cmp_byte(8'h00, {7'h00, o_reg.valid});
   endtask : reg_rd

   // Code for one pin, alternate bit for that pin only
   task automatic set_sel(input int pin, input logic alt, input logic [3:0] c);
      reg_wr(OFS_ADDR_ALT, {4'h0, alt & (pin == 2), 1'b0, alt & (pin == 1), alt & (pin == 0)});
      reg_wr(pin == 2 ? OFS_ADDR_SEL34 : OFS_ADDR_SEL12, pin == 0 ? {4'h0, c} : {c, 4'h0});
   endtask : set_sel

   // Expected output period in cycles, zero for a held-low pin
   function automatic int exp_per(input int pin, input logic alt, input logic [3:0] c);
      int m;
      int x;
      int s;
      m = 2 * HP[4];
      s = 2 * HP[5];
      x = 2 * HP[6];
      if (c == 4'h0) return 0;
      if (!alt) begin
         if (c == 4'h1) return 2 * HP[0];
         if (c == 4'h2) return 2 * HP[1];
         if (c == 4'h3) return 2 * HP[3];
         if (c == 4'h4) return 2 * HP[2];
         if (c <= 4'ha) return m * MD[c - 5];
         if (c == 4'hb) return (pin == 2) ? x * 2 : x * 64;
         return x * XD[c - 12];
      end
      case (c)
         4'h1: return (pin == 2) ? m * 2 : m * 64;
         4'h2: return (pin == 2) ? m : x * 20;
         4'h3: return (pin == 2) ? x * 10 : x * 12;
         4'h4: return (pin == 2) ? s * 10 : x * 10;
         4'h5: return (pin == 2) ? s * 2 : ((pin == 0) ? s * 10 : x * 5);
         4'h6: return (pin == 2) ? s : ((pin == 0) ? s * 5 : x * 2);
         4'h7: return 2 * HP[7];
         default: return 2 * HP[8];
      endcase
   endfunction : exp_per

   // Period between the second and third rising edges, or stuck-low check
   task automatic measure(input int pin, input int exp);
      int   n;
      int   t0;
      int   t1;
      logic seen;
      n = 0;
      t1 = 0;
      seen = 1'b0;
      if (exp == 0) begin
         repeat (64) begin
            @(posedge i_clk) #1;
            seen = seen | o_ck[pin];
         end
         cmp_byte(8'h00, {7'h00, seen});
      end else begin
         repeat (3) begin
            while (o_ck[pin] !== 1'b0 && n < 4 * exp + 64) begin
               @(posedge i_clk) #1;
               n++;
            end
            while (o_ck[pin] !== 1'b1 && n < 4 * exp + 64) begin
               @(posedge i_clk) #1;
               n++;
            end
            t0 = t1;
            t1 = n;
         end
         cmp_per(exp, t1 - t0);
      end
   endtask : measure

   task automatic test_reset_values();
      reg_rd(OFS_ADDR_ALT, 8'h00);
      reg_rd(OFS_ADDR_SEL12, 8'h85);
      reg_rd(OFS_ADDR_SEL34, 8'h86);
      measure(1, exp_per(1, 1'b0, 4'h8));
      measure(0, exp_per(0, 1'b0, 4'h5));
   endtask : test_reset_values

   task automatic test_reg_access();
      reg_wr(OFS_ADDR_ALT, 8'hff);
      reg_rd(OFS_ADDR_ALT, 8'h7f);
      reg_wr(OFS_ADDR_SEL34, 8'h5a);
      reg_rd(OFS_ADDR_SEL34, 8'h5a);
      reg_wr(8'h62, 8'h33);
      reg_rd(8'h62, 8'h00);
      i_srst = 1'b1;
      @(posedge i_clk) #1;
      i_srst = 1'b0;
      reg_rd(OFS_ADDR_SEL34, 8'h86);
      reg_rd(OFS_ADDR_ALT, 8'h00);
   endtask : test_reg_access

   // Other alternate bits leave pin a standard; pin b follows its own bit
   task automatic test_alt_isolation();
      reg_wr(OFS_ADDR_ALT, 8'h7e);
      reg_wr(OFS_ADDR_SEL12, 8'h11);
      measure(0, exp_per(0, 1'b0, 4'h1));
      measure(1, exp_per(1, 1'b1, 4'h1));
   endtask : test_alt_isolation

   // Every code of both tables on every pin; alternate stops at 8
   task automatic test_codes(input logic alt);
      for (int p = 0; p < 3; p++) begin
         for (int c = 0; c < (alt ? 9 : 16); c++) begin
            set_sel(p, alt, c[3:0]);
            measure(p, exp_per(p, alt, c[3:0]));
         end
      end
   endtask : test_codes

   // Main sequence
   initial begin
      i_srst = 1'b1;
      i_reg = '0;
      repeat (4) @(posedge i_clk);
      #1;
      i_srst = 1'b0;
      test_reset_values();
      test_reg_access();
      test_alt_isolation();
      test_codes(1'b0);
      test_codes(1'b1);
      complete_run();
   end

endmodule : ofs_tb_top

// file: ofs_top.sv
// Output clock source and ratio selector for pins a, b and d
`timescale 1ns/100ps
module ofs_top (
   input  wire logic                  i_clk,
   input  wire logic                  i_srst,
   input  wire ofs_pkg::ofs_reg_req_t i_reg,
   input  wire ofs_pkg::ofs_src_in_t  i_src,
   output ofs_pkg::ofs_reg_rsp_t      o_reg,
   output logic                       o_clock_out_a,
   output logic                       o_clock_out_b,
   output logic                       o_clock_out_d
);
   import ofs_pkg::*;

   logic [7:0]             output_freq_select_1_2;
   logic [7:0]             output_freq_select_3_4;
   logic [7:0]             alt_decode_select_reg;
   logic [OFS_NUM_SRC-1:0] sync1;
   logic [OFS_NUM_SRC-1:0] sync2;
   logic [OFS_NUM_SRC-1:0] sync3;
   logic [OFS_NUM_SRC-1:0] lvl;
   logic [OFS_NUM_CH-1:0]  ch_clk;

   // Build a selection from source and ratio
   function automatic ofs_sel_t mk(input ofs_src_t src, input ofs_div_t div);
      ofs_sel_t s;
      s.src = src;
      s.div = div;
      return s;
   endfunction : mk

   // Code to source and ratio for one channel
   function automatic ofs_sel_t decode(input logic [3:0] code, input logic alt, input logic [1:0] ch);
      ofs_sel_t s;
      s = mk(SRC_OFF, 7'h01);
      if (!alt) begin
         case (code)
            4'h1:    s = mk(SRC_2K, 7'h01);
            4'h2:    s = mk(SRC_8K, 7'h01);
            4'h3:    s = mk(SRC_SYN_B, 7'h01);
            4'h4:    s = mk(SRC_SYN_A, 7'h01);
            4'h5:    s = mk(SRC_MAIN, 7'h30);
            4'h6:    s = mk(SRC_MAIN, 7'h10);
            4'h7:    s = mk(SRC_MAIN, 7'h0c);
            4'h8:    s = mk(SRC_MAIN, 7'h08);
            4'h9:    s = mk(SRC_MAIN, 7'h06);
            4'ha:    s = mk(SRC_MAIN, 7'h04);
            4'hb:    s = mk(SRC_AUX, (ch == OFS_CH_D) ? 7'h02 : 7'h40);
            4'hc:    s = mk(SRC_AUX, 7'h30);
            4'hd:    s = mk(SRC_AUX, 7'h10);
            4'he:    s = mk(SRC_AUX, 7'h08);
            4'hf:    s = mk(SRC_AUX, 7'h04);
            default: s = mk(SRC_OFF, 7'h01);
         endcase
      end else if (ch == OFS_CH_D) begin
         case (code)
            4'h1:    s = mk(SRC_MAIN, 7'h02);
            4'h2:    s = mk(SRC_MAIN, 7'h01);
            4'h3:    s = mk(SRC_AUX, 7'h0a);
            4'h4:    s = mk(SRC_MAIN2, 7'h0a);
            4'h5:    s = mk(SRC_MAIN2, 7'h02);
            4'h6:    s = mk(SRC_MAIN2, 7'h01);
            4'h7:    s = mk(SRC_REF_AUX, 7'h01);
            4'h8:    s = mk(SRC_REF_MAIN, 7'h01);
            default: s = mk(SRC_OFF, 7'h01);
         endcase
      end else begin
         case (code)
            4'h1:    s = mk(SRC_MAIN, 7'h40);
            4'h2:    s = mk(SRC_AUX, 7'h14);
            4'h3:    s = mk(SRC_AUX, 7'h0c);
            4'h4:    s = mk(SRC_AUX, 7'h0a);
            4'h5:    s = (ch == OFS_CH_A) ? mk(SRC_MAIN2, 7'h0a) : mk(SRC_AUX, 7'h05);
            4'h6:    s = (ch == OFS_CH_A) ? mk(SRC_MAIN2, 7'h05) : mk(SRC_AUX, 7'h02);
            4'h7:    s = mk(SRC_REF_AUX, 7'h01);
            4'h8:    s = mk(SRC_REF_MAIN, 7'h01);
            default: s = mk(SRC_OFF, 7'h01);
         endcase
      end
      return s;
   endfunction : decode

   // Register write and read decode
   wire        hit_sel12 = (i_reg.addr == OFS_ADDR_SEL12);
   wire        hit_sel34 = (i_reg.addr == OFS_ADDR_SEL34);
   wire        hit_alt   = (i_reg.addr == OFS_ADDR_ALT);
   wire        wr_sel12  = i_reg.wr && hit_sel12;
   wire        wr_sel34  = i_reg.wr && hit_sel34;
   wire        wr_alt    = i_reg.wr && hit_alt;
   wire [7:0]  rd_mux    = hit_sel12 ? output_freq_select_1_2 :
                           hit_sel34 ? output_freq_select_3_4 :
                           hit_alt   ? alt_decode_select_reg  : 8'h00;

   // Register file; fields feed the decoders with no further access
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         output_freq_select_1_2 <= OFS_RST_SEL12;
         output_freq_select_3_4 <= OFS_RST_SEL34;
         alt_decode_select_reg  <= OFS_RST_ALT;
         o_reg                  <= '0;
      end else begin
         if (wr_sel12) begin
            output_freq_select_1_2 <= i_reg.wdata;
         end
         if (wr_sel34) begin
            output_freq_select_3_4 <= i_reg.wdata;
         end
         if (wr_alt) begin
            alt_decode_select_reg <= i_reg.wdata & OFS_ALT_MASK;
         end
         o_reg.valid <= i_reg.rd;
         o_reg.data  <= i_reg.rd ? rd_mux : 8'h00;
      end
   end

   // Three-stage source synchroniser; level moves once stages two and three agree
   wire [OFS_NUM_SRC-1:0] src_vec = i_src;
   wire [OFS_NUM_SRC-1:0] rise    = sync2 & sync3 & ~lvl;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         lvl   <= '0;
      end else begin
         sync1 <= src_vec;
         sync2 <= sync1;
         sync3 <= sync2;
         lvl   <= (sync2 & sync3) | (lvl & (sync2 | sync3));
      end
   end

   // Per-channel code, alternate bit and channel number
   wire [3:0] ch_code [OFS_NUM_CH];
   wire       ch_alt  [OFS_NUM_CH];
   wire [1:0] ch_num  [OFS_NUM_CH];
   ofs_sel_t  sel     [OFS_NUM_CH];

   assign ch_code[0] = output_freq_select_1_2[OFS_OUT1_LSB +: 4];
   assign ch_code[1] = output_freq_select_1_2[OFS_OUT2_LSB +: 4];
   assign ch_code[2] = output_freq_select_3_4[OFS_OUT4_LSB +: 4];
   assign ch_alt[0]  = alt_decode_select_reg[OFS_ALT_BIT_OUT1];
   assign ch_alt[1]  = alt_decode_select_reg[OFS_ALT_BIT_OUT2];
   assign ch_alt[2]  = alt_decode_select_reg[OFS_ALT_BIT_OUT4];
   assign ch_num[0]  = OFS_CH_A;
   assign ch_num[1]  = OFS_CH_B;
   assign ch_num[2]  = OFS_CH_D;

   // One decoder, source mux and divider per channel
   for (genvar g = 0; g < OFS_NUM_CH; g++) begin : g_ch
      wire [3:0] idx     = sel[g].src - 4'h1;
      wire       is_off  = (sel[g].src == SRC_OFF);
      wire       s_rise  = is_off ? 1'b0 : rise[idx];
      wire       s_level = is_off ? 1'b0 : lvl[idx];

      assign sel[g] = decode(ch_code[g], ch_alt[g], ch_num[g]);

      ofs_div_chan ofs_div_chan_inst (
         .i_clk   (i_clk),
         .i_srst  (i_srst),
         .i_sel   (sel[g]),
         .i_rise  (s_rise),
         .i_level (s_level),
         .o_clk   (ch_clk[g])
      );
   end

   assign o_clock_out_a = ch_clk[0];
   assign o_clock_out_b = ch_clk[1];
   assign o_clock_out_d = ch_clk[2];

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_write_off_a;
      wr_sel12 && i_reg.wdata[3:0] == 4'h0 ##1 !wr_sel12;
   endsequence

   a_reset_defaults: assert property (disable iff (1'b0) $past(i_srst) |->
      output_freq_select_1_2 == 8'h85 && output_freq_select_3_4 == 8'h86 && alt_decode_select_reg == 8'h00)
      else $error("reset values not loaded");
   a_write_field_b: assert property (wr_sel12 |=> sel[1] == decode($past(i_reg.wdata[7:4]), ch_alt[1], OFS_CH_B))
      else $error("pin b code not taken from write");
   a_write_field_d: assert property (wr_sel34 && !wr_alt |=> ch_code[2] == $past(i_reg.wdata[7:4]))
      else $error("pin d code not taken from write");
   a_alt_bit_pos: assert property (wr_alt |=> ch_alt[2] == $past(i_reg.wdata[3]) && !alt_decode_select_reg[7])
      else $error("alternate bit misplaced");
   a_write_off_low: assert property (s_write_off_a |=> !o_clock_out_a)
      else $error("pin a not low after disable");
   a_std_frame: assert property (!ch_alt[0] && ch_code[0] == 4'h2 |-> sel[0].src == SRC_8K)
      else $error("standard code 2 not 8 kHz");
   a_std_main48: assert property (!ch_alt[1] && ch_code[1] == 4'h5 |-> sel[1] == mk(SRC_MAIN, 7'h30))
      else $error("standard code 5 not main by 48");
   a_d_aux_by2: assert property (!ch_alt[2] && ch_code[2] == 4'hb |-> sel[2].div == 7'h02)
      else $error("pin d code 11 ratio wrong");
   a_a_aux_by64: assert property (!ch_alt[0] && ch_code[0] == 4'hb |-> sel[0].div == 7'h40)
      else $error("pin a code 11 ratio wrong");
   a_alt_refs: assert property (ch_alt[1] && ch_code[1] == 4'h7 |-> sel[1].src == SRC_REF_AUX)
      else $error("alternate code 7 not aux reference");
   a_alt_a_second: assert property (ch_alt[0] && ch_code[0] == 4'h6 |-> sel[0] == mk(SRC_MAIN2, 7'h05))
      else $error("pin a alternate 6 wrong");
   a_alt_b_aux2: assert property (ch_alt[1] && ch_code[1] == 4'h6 |-> sel[1] == mk(SRC_AUX, 7'h02))
      else $error("pin b alternate 6 wrong");
   a_alt_d_main: assert property (ch_alt[2] && ch_code[2] == 4'h2 |-> sel[2] == mk(SRC_MAIN, 7'h01))
      else $error("pin d alternate 2 wrong");

endmodule : ofs_top
